// ### common/acc_pkg.sv
// constants for the auxiliary control register, dual pointer and config readout
// assumes a cpu core on the same clock issues pointer ops, sfr accesses and memory reads
package acc_pkg;
  // -------------------------------------------------------------
  // auxiliary control register fields
  // -------------------------------------------------------------
  localparam int ACC_SOFT_RESET_BIT = 3;
  localparam int ACC_WIRED_ZERO_BIT = 2;
  localparam int ACC_RESERVED_BIT = 1;
  localparam int ACC_POINTER_SELECT_BIT = 0;
  localparam logic [7:0] ACC_AUX_RESET = 8'h00;
  localparam logic [7:0] ACC_AUX_WRITE_MASK = 8'hFB;
  // -------------------------------------------------------------
  // nonvolatile space addresses
  // -------------------------------------------------------------
  localparam logic [15:0] ACC_SIG_ADDR0 = 16'hFC30;
  localparam logic [15:0] ACC_SIG_ADDR1 = 16'hFC31;
  localparam logic [15:0] ACC_SIG_ADDR2 = 16'hFC60;
  localparam logic [15:0] ACC_CUST_FIRST = 16'hFCE0;
  localparam logic [15:0] ACC_CUST_LAST = 16'hFCFF;
  localparam logic [15:0] ACC_CFG1_ADDR = 16'hFD00;
  localparam logic [15:0] ACC_CFG2_ADDR = 16'hFD01;
  localparam logic [15:0] ACC_RESTART_ADDR = 16'h0000;
  localparam int ACC_CUST_DEPTH = 32;
  // -------------------------------------------------------------
  // config byte one fields
  // -------------------------------------------------------------
  localparam int ACC_CFG_WDOG_EN_BIT = 7;
  localparam int ACC_CFG_RST_PIN_DIS_BIT = 6;
  localparam int ACC_CFG_PORT_LEVEL_BIT = 5;
  localparam int ACC_CFG_BROWNOUT_V_BIT = 4;
  localparam int ACC_CFG_CLK_RATE_BIT = 3;
  localparam logic [2:0] ACC_OSC_EXTERNAL = 3'h7;
  localparam logic [2:0] ACC_OSC_INT_RC = 3'h3;
  localparam logic [2:0] ACC_OSC_LOW_XTAL = 3'h2;
  localparam logic [2:0] ACC_OSC_MED_XTAL = 3'h1;
  localparam logic [2:0] ACC_OSC_HIGH_XTAL = 3'h0;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int ACC_SOFT_RESET_NS = 1000;
  localparam int ACC_CLK_PERIOD_NS = 10;
  localparam int ACC_SOFT_RESET_CYC = ACC_SOFT_RESET_NS / ACC_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ACC_OSC_SEL_EXTERNAL,
    ACC_OSC_SEL_INT_RC,
    ACC_OSC_SEL_LOW,
    ACC_OSC_SEL_MEDIUM,
    ACC_OSC_SEL_HIGH,
    ACC_OSC_SEL_RESERVED
  } acc_osc_mode_t;

  typedef enum logic [1:0] {
    ACC_PTR_NONE,
    ACC_PTR_INC,
    ACC_PTR_LOAD16,
    ACC_PTR_BYTE_WR
  } acc_ptr_op_t;
endpackage : acc_pkg

// ### design/acc_cust_mem.sv
// 32-byte customer data area, read only from the core, loaded by programming
// assumes the programming path writes only while the core is idle
module acc_cust_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic sys_clk_i,
  input wire logic clk_en_i,
  input wire logic prog_we_i,
  input wire logic [AW-1:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rd_data_ff;

  initial
  begin
    if (DEPTH != (1 << AW))
    begin
      $error("acc_cust_mem: DEPTH must equal 2**AW");
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (clk_en_i && prog_we_i)
    begin
      mem[prog_addr_i] <= prog_data_i;
    end
  end

  // nonvolatile contents are not cleared by reset, so no reset here
  always_ff @(posedge sys_clk_i)
  begin
    if (clk_en_i)
    begin
      rd_data_ff <= mem[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_ff;
endmodule : acc_cust_mem

// ### design/acc_top.sv
// auxiliary control register, dual data pointer and nonvolatile readout
// assumes a core on sys_clk_i; all requests are same-clock single-cycle strobes
module acc_top
  import acc_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h11, // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h22, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h33  // arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic ext_reset_i,
  input wire logic wdog_reset_i,
  input wire logic aux_wr_i,
  input wire logic [7:0] aux_wdata_i,
  input wire acc_pkg::acc_ptr_op_t ptr_op_i,
  input wire logic ptr_byte_hi_i,
  input wire logic [15:0] ptr_wdata_i,
  input wire logic [7:0] acc_offset_i,
  input wire logic code_rd_i,
  input wire logic code_from_ptr_i,
  input wire logic [15:0] code_addr_i,
  input wire logic xdata_rd_i,
  input wire logic [7:0] cfg_byte_one_i,
  input wire logic [7:0] cfg_byte_two_i,
  input wire logic prog_we_i,
  input wire logic [4:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic wdog_run_sw_i,
  output logic [7:0] aux_rdata_o,
  output logic [7:0] ptr_high_o,
  output logic [7:0] ptr_low_o,
  output logic [15:0] jump_addr_o,
  output logic nv_rd_valid_o,
  output logic [7:0] nv_rd_data_o,
  output logic nv_hit_o,
  output logic exec_fault_o,
  output logic sys_reset_o,
  output logic [15:0] fetch_restart_o,
  output logic wdog_run_o,
  output logic [7:0] cfg_byte_one_o,
  output acc_pkg::acc_osc_mode_t osc_mode_o
);
  import acc_pkg::*;

  // -------------------------------------------------------------
  // reset synchroniser and combined reset
  // -------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic soft_rst_req;
  logic [7:0] rst_cnt_ff;
  logic sys_reset_ff;
  logic core_rst;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // external reset is a pin, so it is synchronised before use
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ext_meta_ff <= ext_reset_i;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  assign soft_rst_req = aux_wr_i && aux_wdata_i[ACC_SOFT_RESET_BIT];

  // all three sources share one stretch counter, so their effects are identical
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      rst_cnt_ff <= 8'(ACC_SOFT_RESET_CYC);
      sys_reset_ff <= 1'b1;
    end
    else if (clk_en_i)
    begin
      if (soft_rst_req || ext_sync_ff || wdog_reset_i)
      begin
        rst_cnt_ff <= 8'(ACC_SOFT_RESET_CYC);
        sys_reset_ff <= 1'b1;
      end
      else if (rst_cnt_ff != 8'h00)
      begin
        rst_cnt_ff <= rst_cnt_ff - 8'h01;
        sys_reset_ff <= 1'b1;
      end
      else
      begin
        sys_reset_ff <= 1'b0;
      end
    end
  end

  assign core_rst = sys_reset_ff;

  // -------------------------------------------------------------
  // auxiliary control register
  // -------------------------------------------------------------
  logic [7:0] aux_ff;
  logic [7:0] nxt_aux;
  logic sel;

  // write mask keeps bit 2 at zero; bit 3 never stores since it resets at once
  always_comb
  begin
    nxt_aux = aux_wdata_i & ACC_AUX_WRITE_MASK;
    nxt_aux[ACC_SOFT_RESET_BIT] = 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      aux_ff <= ACC_AUX_RESET;
    end
    else if (clk_en_i)
    begin
      if (core_rst)
      begin
        aux_ff <= ACC_AUX_RESET;
      end
      else if (aux_wr_i && !soft_rst_req)
      begin
        aux_ff <= nxt_aux;
      end
    end
  end

  assign sel = aux_ff[ACC_POINTER_SELECT_BIT];

  // -------------------------------------------------------------
  // dual data pointer
  // -------------------------------------------------------------
  logic [15:0] ptr_ff [2];

  // outside reset only the selected entry changes; the other simply holds
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      ptr_ff[0] <= 16'h0000;
      ptr_ff[1] <= 16'h0000;
    end
    else if (clk_en_i)
    begin
      if (core_rst)
      begin
        ptr_ff[0] <= 16'h0000;
        ptr_ff[1] <= 16'h0000;
      end
      else
      begin
        unique case (ptr_op_i)
          ACC_PTR_NONE: ;
          ACC_PTR_INC: ptr_ff[sel] <= ptr_ff[sel] + 16'h0001;
          ACC_PTR_LOAD16: ptr_ff[sel] <= ptr_wdata_i;
          ACC_PTR_BYTE_WR:
          begin
            if (ptr_byte_hi_i)
            begin
              ptr_ff[sel][15:8] <= ptr_wdata_i[7:0];
            end
            else
            begin
              ptr_ff[sel][7:0] <= ptr_wdata_i[7:0];
            end
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // nonvolatile readout
  // -------------------------------------------------------------
  logic [15:0] rd_addr;
  logic [15:0] ptr_sum;
  logic [7:0] cfg1_ff;
  logic [7:0] cfg2_ff;
  logic cfg_loaded_ff;
  logic [7:0] cust_data;
  logic cust_sel_ff;
  logic [7:0] nv_data_ff;
  logic nv_valid_ff;
  logic nv_hit_ff;
  logic fault_ff;
  logic in_cust;

  function automatic logic [15:0] acc_offset_add(input logic [15:0] base, input logic [7:0] off);
    acc_offset_add = base + {8'h00, off};
  endfunction : acc_offset_add

  assign ptr_sum = acc_offset_add(ptr_ff[sel], acc_offset_i);
  assign rd_addr = xdata_rd_i ? ptr_ff[sel] : (code_from_ptr_i ? ptr_sum : code_addr_i);
  assign in_cust = (rd_addr >= ACC_CUST_FIRST) && (rd_addr <= ACC_CUST_LAST);

  acc_cust_mem #(
    .DEPTH(ACC_CUST_DEPTH),
    .AW(5)
  ) u_cust (
    .sys_clk_i(sys_clk_i),
    .clk_en_i(clk_en_i),
    .prog_we_i(prog_we_i),
    .prog_addr_i(prog_addr_i),
    .prog_data_i(prog_data_i),
    .rd_addr_i(rd_addr[4:0]),
    .rd_data_o(cust_data)
  );

  // config bytes are captured once after power-up release; later resets keep them
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      cfg1_ff <= 8'h00;
      cfg2_ff <= 8'h00;
      cfg_loaded_ff <= 1'b0;
    end
    else if (clk_en_i && !cfg_loaded_ff)
    begin
      cfg1_ff <= cfg_byte_one_i;
      cfg2_ff <= cfg_byte_two_i;
      cfg_loaded_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      nv_data_ff <= 8'h00;
      nv_valid_ff <= 1'b0;
      nv_hit_ff <= 1'b0;
      cust_sel_ff <= 1'b0;
      fault_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      nv_valid_ff <= code_rd_i || xdata_rd_i;
      cust_sel_ff <= code_rd_i && !xdata_rd_i && in_cust;
      fault_ff <= code_rd_i && !code_from_ptr_i && in_cust;
      nv_hit_ff <= 1'b0;
      nv_data_ff <= 8'h00;
      if (xdata_rd_i)
      begin
        if (rd_addr == ACC_CFG1_ADDR)
        begin
          nv_data_ff <= cfg1_ff;
          nv_hit_ff <= 1'b1;
        end
        else if (rd_addr == ACC_CFG2_ADDR)
        begin
          nv_data_ff <= cfg2_ff;
          nv_hit_ff <= 1'b1;
        end
      end
      else if (code_rd_i)
      begin
        nv_hit_ff <= in_cust || rd_addr == ACC_SIG_ADDR0 || rd_addr == ACC_SIG_ADDR1
                     || rd_addr == ACC_SIG_ADDR2;
        if (rd_addr == ACC_SIG_ADDR0)
        begin
          nv_data_ff <= SIG_BYTE0;
        end
        else if (rd_addr == ACC_SIG_ADDR1)
        begin
          nv_data_ff <= SIG_BYTE1;
        end
        else if (rd_addr == ACC_SIG_ADDR2)
        begin
          nv_data_ff <= SIG_BYTE2;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------
  logic [15:0] jump_ff;
  logic wdog_run_ff;
  acc_osc_mode_t osc_ff;

  function automatic acc_osc_mode_t acc_osc_decode(input logic [2:0] code);
    unique case (code)
      ACC_OSC_EXTERNAL: acc_osc_decode = ACC_OSC_SEL_EXTERNAL;
      ACC_OSC_INT_RC: acc_osc_decode = ACC_OSC_SEL_INT_RC;
      ACC_OSC_LOW_XTAL: acc_osc_decode = ACC_OSC_SEL_LOW;
      ACC_OSC_MED_XTAL: acc_osc_decode = ACC_OSC_SEL_MEDIUM;
      ACC_OSC_HIGH_XTAL: acc_osc_decode = ACC_OSC_SEL_HIGH;
      default: acc_osc_decode = ACC_OSC_SEL_RESERVED;
    endcase
  endfunction : acc_osc_decode

  always_ff @(posedge sys_clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      jump_ff <= 16'h0000;
      wdog_run_ff <= 1'b0;
      osc_ff <= ACC_OSC_SEL_EXTERNAL;
    end
    else if (clk_en_i)
    begin
      jump_ff <= ptr_sum;
      wdog_run_ff <= wdog_run_sw_i || cfg1_ff[ACC_CFG_WDOG_EN_BIT];
      osc_ff <= acc_osc_decode(cfg1_ff[2:0]);
    end
  end

  // sfr read views; bit 2 and the unselected pointer never appear
  assign aux_rdata_o = aux_ff;
  assign ptr_high_o = ptr_ff[sel][15:8];
  assign ptr_low_o = ptr_ff[sel][7:0];
  assign jump_addr_o = jump_ff;
  assign nv_rd_valid_o = nv_valid_ff;
  assign nv_rd_data_o = cust_sel_ff ? cust_data : nv_data_ff;
  assign nv_hit_o = nv_hit_ff;
  assign exec_fault_o = fault_ff;
  assign sys_reset_o = sys_reset_ff;
  assign fetch_restart_o = ACC_RESTART_ADDR;
  assign wdog_run_o = wdog_run_ff;
  assign cfg_byte_one_o = cfg1_ff;
  assign osc_mode_o = osc_ff;
endmodule : acc_top

// ### dv/acc_top_chk.sv
// checker for the auxiliary control block, sees the top ports only
// assumes one clock domain and binding onto acc_top
module acc_top_chk
  import acc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic aux_wr_i,
  input wire logic [7:0] aux_wdata_i,
  input wire acc_pkg::acc_ptr_op_t ptr_op_i,
  input wire logic [7:0] acc_offset_i,
  input wire logic code_rd_i,
  input wire logic code_from_ptr_i,
  input wire logic [15:0] code_addr_i,
  input wire logic xdata_rd_i,
  input wire logic [7:0] aux_rdata_o,
  input wire logic [7:0] ptr_high_o,
  input wire logic [7:0] ptr_low_o,
  input wire logic [15:0] jump_addr_o,
  input wire logic nv_rd_valid_o,
  input wire logic [7:0] nv_rd_data_o,
  input wire logic nv_hit_o,
  input wire logic exec_fault_o,
  input wire logic sys_reset_o,
  input wire logic [15:0] fetch_restart_o,
  input wire logic wdog_run_o,
  input wire logic [7:0] cfg_byte_one_o
);
  import acc_pkg::*;

  logic go;
  logic [15:0] ptr;
  assign go = clk_en_i && !sys_reset_o;
  assign ptr = {ptr_high_o, ptr_low_o};
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // ---------------------------------------------------------
  // soft reset sequences
  // ---------------------------------------------------------
  sequence s_soft_req;
    aux_wr_i && go && aux_wdata_i[ACC_SOFT_RESET_BIT];
  endsequence
  sequence s_reset_held;
    sys_reset_o [*8];
  endsequence
  // ---------------------------------------------------------
  // assertions
  // ---------------------------------------------------------
  a_soft_reset_held: assert property (s_soft_req |-> ##[1:3] s_reset_held)
    else $error("soft reset not raised");
  a_reset_clears: assert property ($rose(sys_reset_o) |-> ##2 (aux_rdata_o == 8'h00 && ptr == 16'h0000))
    else $error("reset left state");
  a_restart_zero: assert property (fetch_restart_o == ACC_RESTART_ADDR)
    else $error("restart address wrong");
  a_aux_write_seen: assert property (aux_wr_i && go && !aux_wdata_i[ACC_SOFT_RESET_BIT] |=> aux_rdata_o == ($past(aux_wdata_i) & 8'hF3))
    else $error("aux register view wrong");
  a_wired_zero: assert property (!aux_rdata_o[ACC_WIRED_ZERO_BIT])
    else $error("wired zero bit set");
  a_inc_selected: assert property (ptr_op_i == ACC_PTR_INC && go && !aux_wr_i |=> ptr == $past(ptr) + 16'h0001)
    else $error("increment wrong");
  a_jump_addr: assert property ($past(code_rd_i && code_from_ptr_i && !xdata_rd_i && go) |-> jump_addr_o == $past(ptr) + 16'($past(acc_offset_i)))
    else $error("jump address wrong");
  a_read_pulse: assert property (nv_rd_valid_o == $past((code_rd_i || xdata_rd_i) && go))
    else $error("read valid wrong");
  a_cfg_read: assert property (xdata_rd_i && go && ptr == ACC_CFG1_ADDR |=> nv_hit_o && nv_rd_data_o == cfg_byte_one_o)
    else $error("config read wrong");
  a_miss_zero: assert property (nv_rd_valid_o && !nv_hit_o |-> nv_rd_data_o == 8'h00)
    else $error("miss data not zero");
  a_exec_fault: assert property (code_rd_i && go && !code_from_ptr_i && !xdata_rd_i && code_addr_i >= ACC_CUST_FIRST && code_addr_i <= ACC_CUST_LAST |-> ##[0:1] exec_fault_o)
    else $error("no fetch fault");
  a_wdog_forced: assert property ($past(cfg_byte_one_o[ACC_CFG_WDOG_EN_BIT]) && cfg_byte_one_o[ACC_CFG_WDOG_EN_BIT] && !sys_reset_o |-> wdog_run_o)
    else $error("watchdog not forced");
endmodule : acc_top_chk

bind acc_top acc_top_chk chk (.sys_clk_i, .reset_n_i, .clk_en_i, .aux_wr_i, .aux_wdata_i,
  .ptr_op_i, .acc_offset_i, .code_rd_i, .code_from_ptr_i, .code_addr_i, .xdata_rd_i,
  .aux_rdata_o, .ptr_high_o, .ptr_low_o, .jump_addr_o, .nv_rd_valid_o, .nv_rd_data_o,
  .nv_hit_o, .exec_fault_o, .sys_reset_o, .fetch_restart_o, .wdog_run_o, .cfg_byte_one_o);

// ### dv/aux_control_config_readout_test.sv
// self-checking bench for the auxiliary control block
// assumes acc_top with its default signature parameters; inputs move on falling edges
module aux_control_config_readout_test;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  logic sys_clk_i, reset_n_i, clk_en_i, ext_reset_i, wdog_reset_i, aux_wr_i, ptr_byte_hi_i;
  logic code_rd_i, code_from_ptr_i, xdata_rd_i, prog_we_i, wdog_run_sw_i;
  logic [7:0] aux_wdata_i, acc_offset_i, cfg_byte_one_i, cfg_byte_two_i, prog_data_i;
  logic [15:0] ptr_wdata_i, code_addr_i, jump_addr_o, fetch_restart_o;
  logic [4:0] prog_addr_i;
  acc_ptr_op_t ptr_op_i;
  logic [7:0] aux_rdata_o, ptr_high_o, ptr_low_o, nv_rd_data_o, cfg_byte_one_o;
  logic nv_rd_valid_o, nv_hit_o, exec_fault_o, sys_reset_o, wdog_run_o;
  acc_osc_mode_t osc_mode_o;
  int errors, compares;

  acc_top dut (.sys_clk_i, .reset_n_i, .clk_en_i, .ext_reset_i, .wdog_reset_i, .aux_wr_i,
    .aux_wdata_i, .ptr_op_i, .ptr_byte_hi_i, .ptr_wdata_i, .acc_offset_i, .code_rd_i,
    .code_from_ptr_i, .code_addr_i, .xdata_rd_i, .cfg_byte_one_i, .cfg_byte_two_i, .prog_we_i,
    .prog_addr_i, .prog_data_i, .wdog_run_sw_i, .aux_rdata_o, .ptr_high_o, .ptr_low_o,
    .jump_addr_o, .nv_rd_valid_o, .nv_rd_data_o, .nv_hit_o, .exec_fault_o, .sys_reset_o,
    .fetch_restart_o, .wdog_run_o, .cfg_byte_one_o, .osc_mode_o);

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ---------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc
  // bounded: a stuck reset ends the run instead of hanging it
  task automatic wait_idle;
    int n;
    n = 0;
    while (sys_reset_o !== 1'b0 && n < 300)
    begin
      cyc(1);
      n++;
    end
    if (n >= 300)
    begin
      errors++;
      $display("Error at %0t: reset never ended", $time);
      stop_test();
    end
  endtask : wait_idle
  task automatic por(input logic [7:0] c1);
    reset_n_i = 1'b0;
    cfg_byte_one_i = c1;
    cyc(5);
    reset_n_i = 1'b1;
    cyc(3);
    wait_idle();
  endtask : por
  task automatic aux_wr(input logic [7:0] d);
    aux_wdata_i = d;
    aux_wr_i = 1'b1;
    cyc(1);
    aux_wr_i = 1'b0;
    cyc(1);
  endtask : aux_wr
  task automatic ptr_op(input acc_ptr_op_t op, input logic hi, input logic [15:0] d);
    ptr_op_i = op;
    ptr_byte_hi_i = hi;
    ptr_wdata_i = d;
    cyc(1);
    ptr_op_i = ACC_PTR_NONE;
    cyc(1);
  endtask : ptr_op
  // for xdata or pointer fetches loads the selected pointer with a and reads through it; otherwise fetches directly at a
  task automatic rd(input logic x, fp, input logic [15:0] a, input logic [7:0] off, d,
                    input logic h);
    if (x || fp)
      ptr_op(ACC_PTR_LOAD16, 1'b0, a);
    xdata_rd_i = x;
    code_rd_i = !x;
    code_from_ptr_i = fp;
    code_addr_i = a;
    acc_offset_i = off;
    cyc(1);
    xdata_rd_i = 1'b0;
    code_rd_i = 1'b0;
    if (x || fp)
    begin
      check(16'(nv_rd_valid_o), 16'h0001);
      check(16'(nv_rd_data_o), 16'(d));
      check(16'(nv_hit_o), 16'(h));
    end
    if (fp)
      check(jump_addr_o, a + 16'(off));
    if (!x && !fp)
      check(16'(exec_fault_o), 16'(a >= ACC_CUST_FIRST && a <= ACC_CUST_LAST));
    cyc(1);
  endtask : rd
  // ---------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------
  task automatic t_config;
    logic [2:0] code [6] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0, 3'h5};
    acc_osc_mode_t mode [6] = '{ACC_OSC_SEL_EXTERNAL, ACC_OSC_SEL_INT_RC, ACC_OSC_SEL_LOW,
                               ACC_OSC_SEL_MEDIUM, ACC_OSC_SEL_HIGH, ACC_OSC_SEL_RESERVED};
    for (int i = 0; i < 6; i++)
    begin
      por({i[0], 4'hA, code[i]});
      check(16'(osc_mode_o), 16'(mode[i]));
      check(16'(cfg_byte_one_o), {8'h00, i[0], 4'hA, code[i]});
      check(16'(wdog_run_o), 16'(i[0]));
    end
    cfg_byte_one_i = 8'h00;
    cyc(3);
    check(16'(cfg_byte_one_o), 16'h00D5);
    $display("test config done");
  endtask : t_config
  task automatic t_pointers;
    ptr_op(ACC_PTR_LOAD16, 1'b0, 16'h1234);
    aux_wr(8'h01);
    check(16'(aux_rdata_o), 16'h0001);
    check({ptr_high_o, ptr_low_o}, 16'h0000);
    ptr_op(ACC_PTR_LOAD16, 1'b0, 16'hABFF);
    ptr_op(ACC_PTR_INC, 1'b0, 16'h0000);
    check({ptr_high_o, ptr_low_o}, 16'hAC00);
    ptr_op(ACC_PTR_BYTE_WR, 1'b1, 16'h0055);
    ptr_op(ACC_PTR_BYTE_WR, 1'b0, 16'h0077);
    check({ptr_high_o, ptr_low_o}, 16'h5577);
    clk_en_i = 1'b0;
    ptr_op(ACC_PTR_INC, 1'b0, 16'h0000);
    clk_en_i = 1'b1;
    cyc(1);
    check({ptr_high_o, ptr_low_o}, 16'h5577);
    aux_wr(8'h01);
    aux_wr(8'h04);
    check(16'(aux_rdata_o), 16'h0000);
    check({ptr_high_o, ptr_low_o}, 16'h1234);
    aux_wr(8'h01);
    check({ptr_high_o, ptr_low_o}, 16'h5577);
    $display("test pointers done");
  endtask : t_pointers
  task automatic t_reads;
    prog_we_i = 1'b1;
    prog_addr_i = 5'h05;
    prog_data_i = 8'hA5;
    cyc(1);
    prog_addr_i = 5'h1F;
    prog_data_i = 8'h5A;
    cyc(1);
    prog_we_i = 1'b0;
    cyc(1);
    rd(1'b0, 1'b1, 16'hFC30, 8'h00, 8'h11, 1'b1);
    rd(1'b0, 1'b1, 16'hFC30, 8'h01, 8'h22, 1'b1);
    rd(1'b0, 1'b1, 16'hFC5F, 8'h01, 8'h33, 1'b1);
    rd(1'b0, 1'b1, 16'hFC32, 8'h00, 8'h00, 1'b0);
    rd(1'b0, 1'b1, 16'hFCE0, 8'h05, 8'hA5, 1'b1);
    rd(1'b0, 1'b1, 16'hFCFF, 8'h00, 8'h5A, 1'b1);
    rd(1'b1, 1'b0, 16'hFD00, 8'h00, 8'hD5, 1'b1);
    rd(1'b1, 1'b0, 16'hFD01, 8'h00, 8'h3C, 1'b1);
    rd(1'b1, 1'b0, 16'h0100, 8'h00, 8'h00, 1'b0);
    rd(1'b0, 1'b0, 16'hFCE4, 8'h00, 8'h00, 1'b0);
    rd(1'b0, 1'b0, 16'h0100, 8'h00, 8'h00, 1'b0);
    $display("test reads done");
  endtask : t_reads
  // soft, external and watchdog reset must leave the same state
  task automatic t_resets;
    for (int s = 0; s < 3; s++)
    begin
      ptr_op(ACC_PTR_LOAD16, 1'b0, 16'h4321);
      ext_reset_i = (s == 1);
      wdog_reset_i = (s == 2);
      if (s == 0)
        aux_wr(8'h09);
      else
        cyc(4);
      ext_reset_i = 1'b0;
      wdog_reset_i = 1'b0;
      check(16'(sys_reset_o), 16'h0001);
      wait_idle();
      check(16'(aux_rdata_o), 16'h0000);
      check({ptr_high_o, ptr_low_o}, 16'h0000);
      check(fetch_restart_o, 16'h0000);
      check(16'(cfg_byte_one_o), 16'h00D5);
    end
    $display("test resets done");
  endtask : t_resets

  initial
  begin
    errors = 0;
    compares = 0;
    {ext_reset_i, wdog_reset_i, aux_wr_i, ptr_byte_hi_i, code_rd_i, code_from_ptr_i} = '0;
    {xdata_rd_i, prog_we_i, wdog_run_sw_i, reset_n_i} = '0;
    {aux_wdata_i, acc_offset_i, prog_data_i, prog_addr_i, ptr_wdata_i, code_addr_i} = '0;
    clk_en_i = 1'b1;
    cfg_byte_one_i = 8'h00;
    cfg_byte_two_i = 8'h3C;
    ptr_op_i = ACC_PTR_NONE;
    t_config();
    t_pointers();
    t_reads();
    t_resets();
    stop_test();
  end
endmodule : aux_control_config_readout_test
